// [transport_mapper_regs.vh]
// Register offsets, field positions, reset values and constants
// Assumes inclusion by the transport mapper design files
`ifndef TRANSPORT_MAPPER_REGS_VH
`define TRANSPORT_MAPPER_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_MODE 8'h04
`define OFS_KM1 8'h08
`define OFS_DEVID 8'h0c
`define OFS_THR_LOW 8'h10
`define OFS_THR_HIGH 8'h14
`define OFS_STATUS 8'h18
`define OFS_RATIO 8'h1c

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define CTRL_RUN_BIT 0
`define STAT_KEFF_LSB 0
`define STAT_LANES_LSB 12
`define STAT_OCTETS_LSB 16
`define STAT_ENC66_BIT 20
`define STAT_DUAL_BIT 21
`define RST_MODE 7'h3b
`define RST_KM1 8'h0f
`define RST_DEVID 8'h00
`define RST_THR 15'h7fff

// ----------------------------------------------------------------
// Multiframe constants
// ----------------------------------------------------------------
`define K66_OCTETS 9'h100
`define K_MAX 9'h100
`define RATIO_FRAC_BITS 12

`endif

// [mode_table.v]
// Operating mode lookup: selector value to derived link parameters
// Assumes a combinational consumer; no clock
`timescale 1ns/1ps
module mode_table (
    // Selector
    input wire [6:0] mode,
    // Derived parameters
    output reg valid,
    output reg dual,
    output reg [5:0] decim,
    output reg [3:0] lanes,
    output reg [2:0] octets,
    output reg enc66,
    output reg [8:0] kmin,
    output reg [8:0] kstep,
    output reg [15:0] ratio
);
    always @* begin
        valid = 1'b1;
        dual = 1'b0;
        decim = 6'h10;
        lanes = 4'h1;
        octets = 3'h2;
        enc66 = 1'b0;
        kmin = 9'h010;
        kstep = 9'h008;
        ratio = 16'h1400;
        // ------------------------------------------------------------
        // Mode rows
        // ------------------------------------------------------------
        // only listed modes
        case (mode)
            7'h38: begin
                dual = 1'b1; octets = 3'h4; kmin = 9'h008;
                kstep = 9'h004; ratio = 16'h2800;
            end
            7'h39: begin
                dual = 1'b1; lanes = 4'h2; ratio = 16'h1400;
            end
            7'h3a: begin
                dual = 1'b1; lanes = 4'h4; ratio = 16'h0a00;
            end
            7'h3b: begin
                dual = 1'b1; octets = 3'h4; enc66 = 1'b1;
                ratio = 16'h2100;
            end
            7'h3c: begin
                dual = 1'b1; lanes = 4'h2; enc66 = 1'b1;
                ratio = 16'h1080;
            end
            7'h3d: ratio = 16'h2800;
            7'h3e: begin
                lanes = 4'h2; ratio = 16'h1400;
            end
            7'h3f: begin
                lanes = 4'h4; ratio = 16'h0a00;
            end
            7'h40: begin
                enc66 = 1'b1; ratio = 16'h2100;
            end
            7'h41: begin
                lanes = 4'h2; enc66 = 1'b1; ratio = 16'h1080;
            end
            7'h42: begin
                decim = 6'h20; dual = 1'b1; octets = 3'h4;
                kmin = 9'h008; kstep = 9'h004; ratio = 16'h1400;
            end
            7'h43: begin
                decim = 6'h20; dual = 1'b1; lanes = 4'h2;
                ratio = 16'h0a00;
            end
            7'h44: begin
                decim = 6'h20; dual = 1'b1; octets = 3'h4;
                enc66 = 1'b1; ratio = 16'h1080;
            end
            7'h45: begin
                decim = 6'h20; ratio = 16'h1400;
            end
            7'h46: begin
                decim = 6'h20; lanes = 4'h2; ratio = 16'h0a00;
            end
            7'h47: begin
                decim = 6'h20; enc66 = 1'b1; ratio = 16'h1080;
            end
            default: valid = 1'b0;
        endcase
    end
endmodule // mode_table

// [transport_mapper.v]
// Transport mode selection, lane mapping and octet framing, two links
// Assumes converter samples on clk and a plain register port
//
// Summary of operation
// - In 64b/66b modes multiframe length is derived as 256 times E over F.
// - 8b/10b frame count accepted only within the mode's min:step:max range.
// - Programmed frame count minus one sets multiframe length in frames.
// - Selector accepts only listed modes; each fixes all link parameters.
// - Sixteen lanes as two eight-lane links; every mode uses both links.
// - Each link uses its lowest lanes; unused higher lanes power down.
// - Link A sends device id, link B id plus one; lane id is index.
// - Without decimation 12-bit offset-binary samples fill the octets; no listed mode has decimation 1, so the bypass path is never used.
// - With down-converter 16-bit words: 15 data bits plus overrange bit.
// - All tail bit positions are driven to zero.
// - Every sample is packed most significant bit first.
// - Single channel: low flag above low threshold, high flag above high.
// - Dual channel: each channel carries its own pair of overrange flags.
// - Marked bypass modes report converter count equal to lane count; no listed mode has decimation 1, so none reports it.
// - Mode 59: decimate 16, dual, one lane, 64b/66b, F 4, ratio 2.0625.
// - Mode 63: decimate 16, single, four lanes, 8b/10b, F 2, ratio 0.625.
// - Modes 69 and 71: decimate 32, single, one lane, F 2.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "transport_mapper_regs.vh"
module transport_mapper (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Register port
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    // Down-converter samples
    input wire [14:0] chan_a_i,
    input wire [14:0] chan_a_q,
    input wire [14:0] chan_b_i,
    input wire [14:0] chan_b_q,
    // Bypass samples, offset binary
    input wire [11:0] raw_a,
    input wire [11:0] raw_b,
    // Lanes
    output reg [127:0] lane_octet,
    output reg [15:0] lane_enable,
    output reg [47:0] lane_identifier,
    output reg [7:0] link_a_device_identifier,
    output reg [7:0] link_b_device_identifier,
    // Framing
    output reg frame_start,
    output reg multiframe_start,
    output reg sample_take
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg run_q;
    reg [6:0] link_mode_select_q;
    reg [7:0] frames_per_multiframe_minus_one_q;
    reg [7:0] link_device_identifier_q;
    reg [14:0] overrange_threshold_low_q;
    reg [14:0] overrange_threshold_high_q;
    reg [2:0] octet_q;
    reg [7:0] frame_q;
    reg [31:0] fb_q [0:15];
    wire cur_valid;
    wire cur_dual;
    wire [5:0] cur_decim;
    wire [3:0] cur_lanes;
    wire [2:0] cur_octets;
    wire cur_enc66;
    wire [8:0] cur_kmin;
    wire [8:0] cur_kstep;
    wire [15:0] cur_ratio;
    wire new_valid;
    wire [8:0] new_kmin;
    wire [8:0] new_kstep;
    wire new_dual;
    wire [5:0] new_decim;
    wire [3:0] new_lanes;
    wire [2:0] new_octets;
    wire new_enc66;
    wire [15:0] new_ratio;

    mode_table u_cur (
        .mode(link_mode_select_q),
        .valid(cur_valid),
        .dual(cur_dual),
        .decim(cur_decim),
        .lanes(cur_lanes),
        .octets(cur_octets),
        .enc66(cur_enc66),
        .kmin(cur_kmin),
        .kstep(cur_kstep),
        .ratio(cur_ratio)
    );

    mode_table u_new (
        .mode(wdata[6:0]),
        .valid(new_valid),
        .dual(new_dual),
        .decim(new_decim),
        .lanes(new_lanes),
        .octets(new_octets),
        .enc66(new_enc66),
        .kmin(new_kmin),
        .kstep(new_kstep),
        .ratio(new_ratio)
    );

    // ------------------------------------------------------------
    // Multiframe length
    // ------------------------------------------------------------
    reg [8:0] k_eff;
    wire [8:0] k_new = {1'b0, wdata[7:0]} + 9'h001;
    wire [8:0] step_m1 = cur_kstep - 9'h001;
    wire km1_ok = !cur_enc66 && (k_new >= cur_kmin) &&
        (k_new <= `K_MAX) && ((k_new & step_m1) == 9'h000);
    always @* begin
        if (cur_enc66)
            k_eff = (cur_octets == 3'h4) ? (`K66_OCTETS >> 2) :
                (`K66_OCTETS >> 1);
        else
            k_eff = {1'b0, frames_per_multiframe_minus_one_q} + 9'h001;
    end
    wire [7:0] k_last = k_eff[7:0] - 8'h01;
    wire [2:0] f_last = cur_octets - 3'h1;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    wire mode_wr = wr && (addr == `OFS_MODE) &&
        (wdata[6:0] != link_mode_select_q);
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            run_q <= 1'b0;
            link_mode_select_q <= `RST_MODE;
            frames_per_multiframe_minus_one_q <= `RST_KM1;
            link_device_identifier_q <= `RST_DEVID;
            overrange_threshold_low_q <= `RST_THR;
            overrange_threshold_high_q <= `RST_THR;
        end else if (wr) begin
            case (addr)
                `OFS_CONTROL: run_q <= wdata[`CTRL_RUN_BIT];
                `OFS_MODE: if (new_valid && (wdata[31:7] == 25'h0))
                    link_mode_select_q <= wdata[6:0];
                `OFS_KM1: if (km1_ok)
                    frames_per_multiframe_minus_one_q <= wdata[7:0];
                `OFS_DEVID: link_device_identifier_q <= wdata[7:0];
                `OFS_THR_LOW: overrange_threshold_low_q <= wdata[14:0];
                `OFS_THR_HIGH: overrange_threshold_high_q <= wdata[14:0];
                default: run_q <= run_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    // converter count per link
    wire [3:0] conv_per_link = (cur_decim == 6'h01) ? cur_lanes :
        (cur_dual ? 4'h2 : 4'h1);
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h0;
        end else if (rd) begin
            case (addr)
                `OFS_CONTROL: rdata <= {31'h0, run_q};
                `OFS_MODE: rdata <= {25'h0, link_mode_select_q};
                `OFS_KM1: rdata <= {24'h0,
                    frames_per_multiframe_minus_one_q};
                `OFS_DEVID: rdata <= {24'h0, link_device_identifier_q};
                `OFS_THR_LOW: rdata <= {17'h0, overrange_threshold_low_q};
                `OFS_THR_HIGH: rdata <= {17'h0,
                    overrange_threshold_high_q};
                `OFS_STATUS: rdata <= {conv_per_link, cur_decim, cur_dual,
                    cur_enc66, 1'b0, cur_octets, cur_lanes, 3'h0, k_eff};
                `OFS_RATIO: rdata <= {16'h0, cur_ratio};
                default: rdata <= 32'h0;
            endcase
        end else begin
            rdata <= 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Sample words
    // ------------------------------------------------------------
    function [14:0] mag15;
        input [14:0] x;
        begin
            mag15 = x[14] ? (~x + 15'h0001) : x;
        end
    endfunction

    wire [14:0] mag_ai = mag15(chan_a_i);
    wire [14:0] mag_aq = mag15(chan_a_q);
    wire [14:0] mag_bi = mag15(chan_b_i);
    wire [14:0] mag_bq = mag15(chan_b_q);
    // each channel's flags from both its I and Q samples
    wire chan_a_overrange_low = (mag_ai > overrange_threshold_low_q) ||
        (mag_aq > overrange_threshold_low_q);
    wire chan_a_overrange_high = (mag_ai > overrange_threshold_high_q) ||
        (mag_aq > overrange_threshold_high_q);
    wire chan_b_overrange_low = (mag_bi > overrange_threshold_low_q) ||
        (mag_bq > overrange_threshold_low_q);
    wire chan_b_overrange_high = (mag_bi > overrange_threshold_high_q) ||
        (mag_bq > overrange_threshold_high_q);

    reg [15:0] word_i [0:1];
    reg [15:0] word_q [0:1];
    always @* begin
        // bypass 12-bit with zero tail nibble
        if (cur_decim == 6'h01) begin
            word_i[0] = {raw_a, 4'h0};
            word_q[0] = {raw_a, 4'h0};
            word_i[1] = {raw_b, 4'h0};
            word_q[1] = {raw_b, 4'h0};
        // 15 data bits plus one overrange bit
        end else begin
            word_i[0] = {chan_a_i, chan_a_overrange_low};
            word_q[0] = {chan_a_q, chan_a_overrange_high};
            word_i[1] = {chan_b_i, chan_b_overrange_low};
            word_q[1] = {chan_b_q, chan_b_overrange_high};
        end
    end

    // ------------------------------------------------------------
    // Frame and multiframe counters
    // ------------------------------------------------------------
    wire running = run_q && cur_valid && !mode_wr;
    wire load = running && (octet_q == f_last);
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            octet_q <= 3'h7;
            frame_q <= 8'hff;
            frame_start <= 1'b0;
            multiframe_start <= 1'b0;
            sample_take <= 1'b0;
        end else if (!running) begin
            octet_q <= f_last;
            frame_q <= k_last;
            frame_start <= 1'b0;
            multiframe_start <= 1'b0;
            sample_take <= 1'b0;
        end else begin
            octet_q <= load ? 3'h0 : octet_q + 3'h1;
            if (load)
                frame_q <= (frame_q >= k_last) ? 8'h00 :
                    frame_q + 8'h01;
            frame_start <= load;
            multiframe_start <= load && (frame_q >= k_last);
            sample_take <= load;
        end
    end

    // ------------------------------------------------------------
    // Lanes
    // ------------------------------------------------------------
    genvar l;
    generate
        for (l = 0; l < 16; l = l + 1) begin : g_lane
            localparam integer IDX_N = l % 8;
            localparam [3:0] IDX = IDX_N[3:0];
            localparam LINK = l / 8;
            wire used = running && (IDX < cur_lanes);
            wire odd_frame = (cur_lanes == 4'h1) &&
                (frame_q >= k_last ? 1'b0 : ~frame_q[0]);
            wire pick_q = IDX[0] ^ odd_frame;
            wire [31:0] frame_word = (cur_octets == 3'h4) ?
                {word_i[LINK], word_q[LINK]} :
                {pick_q ? word_q[LINK] : word_i[LINK], 16'h0000};
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    fb_q[l] <= 32'h0;
                    lane_octet[l*8 +: 8] <= 8'h00;
                    lane_enable[l] <= 1'b0;
                    lane_identifier[l*3 +: 3] <= 3'h0;
                end else begin
                    lane_enable[l] <= used;
                    lane_identifier[l*3 +: 3] <= IDX[2:0];
                    if (!used) begin
                        fb_q[l] <= 32'h0;
                        lane_octet[l*8 +: 8] <= 8'h00;
                    end else if (load) begin
                        fb_q[l] <= {frame_word[23:0], 8'h00};
                        lane_octet[l*8 +: 8] <= frame_word[31:24];
                    end else begin
                        fb_q[l] <= {fb_q[l][23:0], 8'h00};
                        lane_octet[l*8 +: 8] <= fb_q[l][31:24];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Device identifiers
    // ------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            link_a_device_identifier <= 8'h00;
            link_b_device_identifier <= 8'h00;
        end else begin
            link_a_device_identifier <= link_device_identifier_q;
            link_b_device_identifier <= link_device_identifier_q +
                8'h01;
        end
    end
endmodule // transport_mapper

// [transport_mapper_properties.sv]
// Port-level checks of lane framing, identifiers and lane power-down
// Assumes binding onto transport_mapper and the register header
`timescale 1ns/1ps
`include "transport_mapper_regs.vh"
module transport_mapper_properties (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Register port
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    // Lanes and framing
    input wire [127:0] lane_octet,
    input wire [15:0] lane_enable,
    input wire [47:0] lane_identifier,
    input wire [7:0] link_a_device_identifier,
    input wire [7:0] link_b_device_identifier,
    input wire frame_start,
    input wire multiframe_start,
    input wire sample_take
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    logic [127:0] en_mask;
    always_comb begin
        for (int l = 0; l < 16; l++) begin
            en_mask[l*8+:8] = {8{lane_enable[l]}};
        end
    end

    // ---------------------------------------------------------
    // Sequences
    // ---------------------------------------------------------
    sequence s_run_on;
        wr && addr == `OFS_CONTROL && wdata[`CTRL_RUN_BIT] && !lane_enable[0];
    endsequence
    sequence s_run_off;
        wr && addr == `OFS_CONTROL && !wdata[`CTRL_RUN_BIT];
    endsequence
    sequence s_frame_hold;
        (frame_start && !wr) ##1 (!wr && lane_enable[0]) [*4];
    endsequence

    // ---------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------
    chk_run_start: assert property (s_run_on |-> ##2 frame_start)
        else $error("first frame late after run");
    chk_run_stop: assert property (s_run_off |->
        ##2 (lane_enable == 16'h0 && lane_octet == 128'h0))
        else $error("lanes still active after stop");
    chk_frame_back: assert property (s_frame_hold |->
        frame_start || $past(frame_start, 2))
        else $error("gap between frames");
    chk_frame_gap: assert property (frame_start |=> !frame_start)
        else $error("frame shorter than two octets");
    chk_id_offset: assert property ($past(resetn) |->
        link_b_device_identifier == link_a_device_identifier + 8'h01)
        else $error("link b id not link a id plus one");
    chk_lane_ids: assert property ($past(resetn) |->
        lane_identifier == 48'hfac688fac688)
        else $error("lane id not lane index");
    chk_lowest_lanes: assert property (
        lane_enable[15:8] == lane_enable[7:0] &&
        ((lane_enable[7:0] + 8'h01) & lane_enable[7:0]) == 8'h00)
        else $error("lanes not lowest indexed");
    chk_unused_zero: assert property ((lane_octet & ~en_mask) == 128'h0)
        else $error("powered down lane carries data");
    chk_both_links: assert property (frame_start |->
        lane_enable[0] && lane_enable[8])
        else $error("frame without both links");
    chk_mf_frame: assert property (multiframe_start |-> frame_start)
        else $error("multiframe start off frame");
    chk_take_frame: assert property (sample_take == frame_start)
        else $error("sample take not with frame start");
endmodule // transport_mapper_properties

bind transport_mapper transport_mapper_properties chk_i (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .lane_octet(lane_octet), .lane_enable(lane_enable),
    .lane_identifier(lane_identifier),
    .link_a_device_identifier(link_a_device_identifier),
    .link_b_device_identifier(link_b_device_identifier),
    .frame_start(frame_start), .multiframe_start(multiframe_start),
    .sample_take(sample_take));

// [jesd_receiver_model.sv]
// Far-end receiver: rebuilds four-octet frames from lane 0 of each link
// Assumes frame_start marks octet 0 on the lanes
`timescale 1ns/1ps
module jesd_receiver_model (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Lanes
    input wire [127:0] lane_octet,
    input wire frame_start,
    // Rebuilt frames
    output reg [31:0] link_a_frame,
    output reg [31:0] link_b_frame,
    output reg frame_valid
);
    reg [23:0] acc_a_q;
    reg [23:0] acc_b_q;
    reg [1:0] idx_q;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idx_q <= 2'h0;
            acc_a_q <= 24'h0;
            acc_b_q <= 24'h0;
            link_a_frame <= 32'h0;
            link_b_frame <= 32'h0;
            frame_valid <= 1'b0;
        end else begin
            frame_valid <= 1'b0;
            if (frame_start || idx_q != 2'h0) begin
                idx_q <= frame_start ? 2'h1 : idx_q + 2'h1;
                acc_a_q <= {acc_a_q[15:0], lane_octet[7:0]};
                acc_b_q <= {acc_b_q[15:0], lane_octet[71:64]};
            end
            if (idx_q == 2'h3 && !frame_start) begin
                link_a_frame <= {acc_a_q, lane_octet[7:0]};
                link_b_frame <= {acc_b_q, lane_octet[71:64]};
                frame_valid <= 1'b1;
            end
        end
    end
endmodule // jesd_receiver_model

// [transport_mapper_tb_top.sv]
// Testbench: register tasks, mode table, framing and overrange words
// Assumes the design, header, checker and receiver model compiled first
`timescale 1ns/1ps
`include "transport_mapper_regs.vh"
module transport_mapper_tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [14:0] chan_a_i = 15'h0300;
    logic [14:0] chan_a_q = 15'h7e00;
    logic [14:0] chan_b_i = 15'h0010;
    logic [14:0] chan_b_q = 15'h5000;
    logic [11:0] raw_a = 12'h800;
    logic [11:0] raw_b = 12'h7ff;
    wire [31:0] rdata;
    wire [127:0] lane_octet;
    wire [15:0] lane_enable;
    wire [7:0] link_a_device_identifier;
    wire [7:0] link_b_device_identifier;
    wire frame_start;
    wire multiframe_start;
    wire [31:0] link_a_frame;
    wire [31:0] link_b_frame;
    wire frame_valid;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;

    always #4 clk = ~clk;

    transport_mapper uut (
        .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .chan_a_i(chan_a_i), .chan_a_q(chan_a_q),
        .chan_b_i(chan_b_i), .chan_b_q(chan_b_q), .raw_a(raw_a),
        .raw_b(raw_b), .lane_octet(lane_octet), .lane_enable(lane_enable),
        .lane_identifier(),
        .link_a_device_identifier(link_a_device_identifier),
        .link_b_device_identifier(link_b_device_identifier),
        .frame_start(frame_start), .multiframe_start(multiframe_start),
        .sample_take());

    jesd_receiver_model rx_i (
        .clk(clk), .resetn(resetn), .lane_octet(lane_octet),
        .frame_start(frame_start), .link_a_frame(link_a_frame),
        .link_b_frame(link_b_frame), .frame_valid(frame_valid));

    // ---------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------
    task automatic finish_test;
        if (miscompares == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input [31:0] got, input [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            miscompares++;
        end
    endtask

    task automatic wr_reg(input [7:0] a, input [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input [7:0] a, input [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask

    task automatic mode_chk(input [6:0] md, input [8:0] k, input [3:0] l,
        input [2:0] f, input e, input dl, input [5:0] dc, input [15:0] r);
        wr_reg(`OFS_MODE, {25'h0, md});
        rd_chk(`OFS_STATUS, {(dl ? 4'h2 : 4'h1), dc, dl, e, 1'b0, f, l,
            3'h0, k});
        rd_chk(`OFS_RATIO, {16'h0, r});
    endtask

    task automatic mf_period(output int n);
        int i;
        for (i = 0; i < 600 && !multiframe_start; i++) @(negedge clk);
        @(negedge clk);
        for (n = 1; n < 600 && !multiframe_start; n++) @(negedge clk);
    endtask

    function automatic logic [31:0] frame_word(input [14:0] i, input [14:0] q,
        input [14:0] tl, input [14:0] th);
        logic [14:0] mi;
        logic [14:0] mq;
        mi = i[14] ? 15'h0 - i : i;
        mq = q[14] ? 15'h0 - q : q;
        return {i, (mi > tl) || (mq > tl), q, (mi > th) || (mq > th)};
    endfunction

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    // ---------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------
    initial begin
        int n;
        int m;
        logic [31:0] fa;
        logic [31:0] fb;
        fa = frame_word(chan_a_i, chan_a_q, 15'h0100, 15'h2000);
        fb = frame_word(chan_b_i, chan_b_q, 15'h0100, 15'h2000);
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rd_chk(`OFS_MODE, 32'h3b);
        rd_chk(`OFS_KM1, 32'h0f);
        rd_chk(`OFS_DEVID, 32'h0);
        rd_chk(`OFS_THR_LOW, 32'h7fff);
        rd_chk(`OFS_THR_HIGH, 32'h7fff);
        wr_reg(8'h40, 32'h5);
        rd_chk(8'h40, 32'h0);
        wr_reg(`OFS_MODE, 32'h37);
        wr_reg(`OFS_MODE, 32'hbf);
        rd_chk(`OFS_MODE, 32'h3b);
        for (m = 56; m < 73; m++) begin
            wr_reg(`OFS_MODE, m);
            rd_chk(`OFS_MODE, m < 72 ? m : 71);
        end
        mode_chk(7'd59, 9'd64, 4'd1, 3'd4, 1'b1, 1'b1, 6'd16, 16'h2100);
        mode_chk(7'd63, 9'd16, 4'd4, 3'd2, 1'b0, 1'b0, 6'd16, 16'h0a00);
        mode_chk(7'd69, 9'd16, 4'd1, 3'd2, 1'b0, 1'b0, 6'd32, 16'h1400);
        mode_chk(7'd71, 9'd128, 4'd1, 3'd2, 1'b1, 1'b0, 6'd32, 16'h1080);
        wr_reg(`OFS_KM1, 32'h1f);
        rd_chk(`OFS_KM1, 32'h0f);
        wr_reg(`OFS_MODE, 32'd63);
        wr_reg(`OFS_KM1, 32'h0e);
        rd_chk(`OFS_KM1, 32'h0f);
        wr_reg(`OFS_KM1, 32'h1a);
        rd_chk(`OFS_KM1, 32'h0f);
        wr_reg(`OFS_KM1, 32'h17);
        rd_chk(`OFS_KM1, 32'h17);
        wr_reg(`OFS_KM1, 32'hff);
        rd_chk(`OFS_KM1, 32'hff);
        wr_reg(`OFS_KM1, 32'h0f);
        wr_reg(`OFS_DEVID, 32'hff);
        repeat (2) @(negedge clk);
        check(link_a_device_identifier, 8'hff);
        check(link_b_device_identifier, 8'h00);
        wr_reg(`OFS_THR_LOW, 32'h0100);
        wr_reg(`OFS_THR_HIGH, 32'h2000);
        wr_reg(`OFS_CONTROL, 32'h1);
        repeat (3) @(negedge clk);
        check(lane_enable, 16'h0f0f);
        for (m = 0; m < 50 && !frame_start; m++) @(negedge clk);
        @(negedge clk);
        check(lane_octet[15:0], {fa[7:0], fa[23:16]});
        check(lane_octet[79:64], {fb[7:0], fb[23:16]});
        mf_period(n);
        check(n, 16 * 2);
        wr_reg(`OFS_MODE, 32'd66);
        wr_reg(`OFS_KM1, 32'h07);
        rd_chk(`OFS_KM1, 32'h07);
        mf_period(n);
        check(n, 8 * 4);
        wr_reg(`OFS_MODE, 32'd59);
        mf_period(n);
        check(n, 256);
        check(lane_enable, 16'h0101);
        for (m = 0; m < 50 && !frame_valid; m++) @(negedge clk);
        check(link_a_frame, fa);
        check(link_b_frame, fb);
        wr_reg(`OFS_CONTROL, 32'h0);
        repeat (3) @(negedge clk);
        check(lane_enable, 16'h0);
        check({31'h0, |lane_octet}, 32'h0);
        finish_test();
    end
endmodule // transport_mapper_tb_top
